//--- shared/mie_pkg.sv
// Constants and types of the instruction execute block
package mie_pkg;
  // APB byte offsets
  localparam logic [11:0] A_CMD  = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_ACC  = 12'h008;
  localparam logic [11:0] A_PC   = 12'h00c;
  localparam logic [11:0] A_STK  = 12'h010;
  localparam logic [11:0] A_WDT  = 12'h014;
  localparam logic [11:0] A_WAKE = 12'h018;
  localparam logic [3:0]  A_MEMH = 4'h1;
  // Data memory address that aliases the low pc byte
  localparam logic [5:0]  PCL_ADDR = 6'h02;
  // Reset values
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [9:0]  PC_RST  = 10'h000;
  localparam logic        GIE_RST = 1'b0;
  // One instruction cycle is four system clocks
  localparam logic [3:0]  ICYC_CLKS = 4'h4;
  localparam logic [3:0]  ONE_CYC   = ICYC_CLKS - 4'h1;
  localparam logic [3:0]  TWO_CYC   = 4'h2 * ICYC_CLKS - 4'h1;
  localparam logic [3:0]  THREE_CYC = 4'h3 * ICYC_CLKS - 4'h1;
  // Command word field positions
  localparam int OP_LSB  = 0;
  localparam int BIT_LSB = 5;
  localparam int ADR_LSB = 8;
  localparam int ARG_LSB = 16;

  typedef enum logic [4:0] {
    OP_NOP    = 5'h00, OP_CLRM  = 5'h01, OP_CLRB  = 5'h02,
    OP_WDTCLR = 5'h03, OP_WDT1  = 5'h04, OP_WDT2  = 5'h05,
    OP_INV    = 5'h06, OP_INVW  = 5'h07, OP_DECADJ = 5'h08,
    OP_DECM   = 5'h09, OP_DECW  = 5'h0a, OP_INCM  = 5'h0b,
    OP_INCW   = 5'h0c, OP_HALT  = 5'h0d, OP_JUMP  = 5'h0e,
    OP_MOVI   = 5'h0f, OP_MOVMW = 5'h10, OP_MOVWM = 5'h11,
    OP_ORW    = 5'h12, OP_ORI   = 5'h13, OP_ORM   = 5'h14,
    OP_RET    = 5'h15, OP_RETK  = 5'h16, OP_IRET  = 5'h17,
    OP_ROL    = 5'h18
  } mie_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_EXEC = 2'h1, ST_HALT = 2'h2
  } mie_st_t;

  typedef struct packed {
    logic timeout_flag;
    logic power_down_flag;
    logic overflow_flag;
    logic z;
    logic half_carry_flag;
    logic c;
  } mie_flags_t;

  typedef struct packed {
    logic [9:0] arg;
    logic [5:0] addr;
    logic [2:0] bitsel;
    logic [4:0] op;
  } mie_cmd_t;
endpackage

//--- design/mie_exec.sv
// Instruction execute subset with data memory, flags and watchdog
//
// Operation
// - Byte clear writes zero to memory, no flag changes.
// - Bit clear zeroes only the selected bit, no flag changes.
// - Watchdog clear zeroes count and clears power-down and timeout.
// - Both pre-clears executed clear count and both flags.
// - A lone pre-clear only records itself, flags unchanged.
// - Invert flips memory byte in place, updates zero flag.
// - Invert-to-working puts inverse in accumulator, memory kept.
// - Adjust low nibble by six above nine or half carry.
// - Adjust high nibble plus nibble carry; only carry changes.
// - Decrement by one to memory or accumulator, zero flag updated.
// - Increment by one to memory or accumulator, zero flag updated.
// - Halt stops execution, keeps data, clears watchdog and prescaler.
// - Halt sets power-down, clears timeout, advances pc by one.
// - Jump loads pc from the command, no flag changes.
// - Immediate move loads eight-bit constant into accumulator.
// - Moves copy between accumulator and memory, flags kept.
// - No-operation only advances the pc.
// - OR updates zero flag; destination memory or accumulator.
// - Return pops pc from stack in two instruction cycles.
// - Return-with-constant pops pc and loads accumulator.
// - Interrupt return pops pc and sets global interrupt enable.
// - Rotate left moves bit seven into bit zero, no flags.
// - Writing the low pc byte adds one instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module mie_exec
  import mie_pkg::*;
(
  input  wire logic        pclk,     // System clock
  input  wire logic        presetn,  // Async reset, active low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [11:0] paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error
  output logic             busy,     // Instruction in progress
  output logic             halted,   // Clock gated, power down
  output logic             gie       // Global interrupt enable
);

  typedef struct packed {
    mie_st_t           st;
    logic [3:0]        cnt;
    mie_flags_t        fl;
    logic [7:0]        acc;
    logic [9:0]        pc;
    logic [3:0][9:0]   stk;
    logic [1:0]        sp;
    logic [7:0]        wdt;
    logic [7:0]        pre;
    logic              pre1;
    logic              pre2;
    logic              gie;
    logic [63:0][7:0]  mem;
    logic [31:0]       rdata;
  } mie_state_t;

  mie_state_t r_reg;
  mie_state_t r_next;
  mie_cmd_t   cmd;
  logic       wr;
  logic       issue;
  logic       mapped;
  logic       to_evt;

  ////////////////////////////////////////////////////////////////
  // Bus decode

  assign cmd = {pwdata[ARG_LSB +: 10], pwdata[ADR_LSB +: 6],
                pwdata[BIT_LSB +: 3], pwdata[OP_LSB +: 5]};
  assign wr = psel & penable & pwrite;
  assign issue = wr & (paddr == A_CMD) & (r_reg.st == ST_IDLE);
  assign mapped = (paddr[1:0] == 2'h0) &
                  ((paddr[11:8] == A_MEMH) ||
                   (paddr == A_CMD) || (paddr == A_STAT) ||
                   (paddr == A_ACC) || (paddr == A_PC) ||
                   (paddr == A_STK) || (paddr == A_WDT) ||
                   (paddr == A_WAKE));
  // Zero wait states; read data was captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = r_reg.rdata;
  assign busy = (r_reg.st == ST_EXEC);
  assign halted = (r_reg.st == ST_HALT);
  assign gie = r_reg.gie;
  // Watchdog overflow; gated off while halted
  assign to_evt = (r_reg.st != ST_HALT) &
                  (r_reg.pre == 8'hff) & (r_reg.wdt == 8'hff);

  ////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] m, res;
    logic       wm, wa, zu, ac1;
    logic [3:0] cyc;
    logic [4:0] lo, hi;
    m = 8'h00;
    res = 8'h00;
    wm = 1'b0;
    wa = 1'b0;
    zu = 1'b0;
    cyc = ONE_CYC;
    lo = 5'h00;
    hi = 5'h00;
    ac1 = 1'b0;
    r_next = r_reg;

    // Watchdog runs on every clock unless the clock is gated
    if (r_reg.st != ST_HALT) begin
      r_next.pre = r_reg.pre + 8'h01;
      if (r_reg.pre == 8'hff) begin
        r_next.wdt = r_reg.wdt + 8'h01;
      end
    end

    case (r_reg.st)
      ST_IDLE: begin
        if (issue) begin
          m = (cmd.addr == PCL_ADDR) ? r_reg.pc[7:0]
                                     : r_reg.mem[cmd.addr];
          r_next.pc = r_reg.pc + 10'h001;
          case (mie_op_t'(cmd.op))
            OP_CLRM, OP_CLRB: begin
              res = (cmd.op == OP_CLRB) ? (m & ~(8'h01 << cmd.bitsel)) : 8'h00;
              wm = 1'b1;
            end
            OP_WDTCLR: begin
              r_next.wdt = 8'h00;
              r_next.pre = 8'h00;
              r_next.fl.timeout_flag = 1'b0;
              r_next.fl.power_down_flag = 1'b0;
            end
            OP_WDT1, OP_WDT2: begin
              if ((cmd.op == OP_WDT1) ? r_reg.pre2 : r_reg.pre1) begin
                r_next.wdt = 8'h00;
                r_next.pre = 8'h00;
                r_next.fl.timeout_flag = 1'b0;
                r_next.fl.power_down_flag = 1'b0;
                r_next.pre1 = 1'b0;
                r_next.pre2 = 1'b0;
              end else begin
                r_next.pre1 = r_reg.pre1 | (cmd.op == OP_WDT1);
                r_next.pre2 = r_reg.pre2 | (cmd.op == OP_WDT2);
              end
            end
            OP_INV, OP_INVW: begin
              res = ~m;
              wm = (cmd.op == OP_INV);
              wa = (cmd.op == OP_INVW);
              zu = 1'b1;
            end
            OP_DECADJ: begin
              lo = {1'b0, r_reg.acc[3:0]} +
                   ((r_reg.acc[3:0] > 4'h9 || r_reg.fl.half_carry_flag) ? 5'h06 : 5'h00);
              ac1 = lo[4];
              hi = {1'b0, r_reg.acc[7:4]} + {4'h0, ac1};
              if (hi > 5'h09 || r_reg.fl.c) begin
                hi = hi + 5'h06;
                r_next.fl.c = 1'b1;
              end
              res = {hi[3:0], lo[3:0]};
              wm = 1'b1;
            end
            OP_DECM, OP_DECW, OP_INCM, OP_INCW: begin
              res = (cmd.op == OP_INCM || cmd.op == OP_INCW) ? m + 8'h01 : m - 8'h01;
              wm = (cmd.op == OP_DECM || cmd.op == OP_INCM);
              wa = (cmd.op == OP_DECW || cmd.op == OP_INCW);
              zu = 1'b1;
            end
            OP_HALT: begin
              // gate clock, clear watchdog and prescaler
              r_next.wdt = 8'h00;
              r_next.pre = 8'h00;
              r_next.fl.power_down_flag = 1'b1;
              r_next.fl.timeout_flag = 1'b0;
            end
            OP_JUMP: begin
              r_next.pc = cmd.arg;
              cyc = TWO_CYC;
            end
            OP_MOVI, OP_MOVMW: begin
              res = (cmd.op == OP_MOVI) ? cmd.arg[7:0] : m;
              wa = 1'b1;
            end
            OP_MOVWM: begin
              res = r_reg.acc;
              wm = 1'b1;
            end
            OP_ORW, OP_ORM, OP_ORI: begin
              res = r_reg.acc | ((cmd.op == OP_ORI) ? cmd.arg[7:0] : m);
              wm = (cmd.op == OP_ORM);
              wa = (cmd.op != OP_ORM);
              zu = 1'b1;
            end
            OP_RET, OP_RETK, OP_IRET: begin
              r_next.sp = r_reg.sp - 2'h1;
              r_next.pc = r_reg.stk[r_reg.sp - 2'h1];
              cyc = TWO_CYC;
              res = cmd.arg[7:0];
              wa = (cmd.op == OP_RETK);
              r_next.gie = r_reg.gie | (cmd.op == OP_IRET);
            end
            OP_ROL: begin
              res = {m[6:0], m[7]};
              wm = 1'b1;
            end
            default: res = 8'h00;
          endcase
          if (wa) begin
            r_next.acc = res;
          end
          if (zu) begin
            r_next.fl.z = (res == 8'h00);
          end
          if (wm) begin
            // pc low byte load costs a cycle
            if (cmd.addr == PCL_ADDR) begin
              r_next.pc = {r_reg.pc[9:8], res};
              cyc = TWO_CYC;
            end else begin
              r_next.mem[cmd.addr] = res;
            end
          end
          r_next.cnt = cyc;
          r_next.st = (cmd.op == OP_HALT) ? ST_HALT : ST_EXEC;
        end
      end
      ST_EXEC: begin
        r_next.cnt = r_reg.cnt - 4'h1;
        if (r_reg.cnt == 4'h1) begin
          r_next.st = ST_IDLE;
        end
      end
      ST_HALT: begin
        if (wr && paddr == A_WAKE) begin
          r_next.st = ST_IDLE;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase
    // Timeout is set after any clear so a coincident event is kept
    if (to_evt) begin
      r_next.fl.timeout_flag = 1'b1;
    end
    // Software access; command word handled above
    if (wr && r_reg.st != ST_HALT) begin
      if (paddr == A_STAT) begin
        r_next.fl.c = pwdata[0];
        r_next.fl.half_carry_flag = pwdata[1];
        r_next.fl.z = pwdata[2];
        r_next.fl.overflow_flag = pwdata[3];
        r_next.gie = pwdata[8];
      end
      if (paddr == A_ACC && !issue) begin
        r_next.acc = pwdata[7:0];
      end
      if (paddr == A_PC && r_reg.st == ST_IDLE) begin
        r_next.pc = pwdata[9:0];
      end
      if (paddr == A_STK && r_reg.st == ST_IDLE) begin
        r_next.stk[r_reg.sp] = pwdata[9:0];
        r_next.sp = r_reg.sp + 2'h1;
      end
      if (paddr[11:8] == A_MEMH && paddr[1:0] == 2'h0) begin
        r_next.mem[paddr[7:2]] = pwdata[7:0];
      end
    end
    // Read data captured in the setup phase
    if (psel && !penable && !pwrite) begin
      r_next.rdata = 32'h0000_0000;
      if (paddr == A_STAT) begin
        r_next.rdata = {19'h0, r_reg.pre2, r_reg.pre1,
                        r_reg.st, r_reg.gie, 2'h0, r_reg.fl};
      end else if (paddr == A_ACC) begin
        r_next.rdata = {24'h0, r_reg.acc};
      end else if (paddr == A_PC) begin
        r_next.rdata = {22'h0, r_reg.pc};
      end else if (paddr == A_STK) begin
        r_next.rdata = {20'h0, r_reg.sp,
                        r_reg.stk[r_reg.sp - 2'h1]};
      end else if (paddr == A_WDT) begin
        r_next.rdata = {16'h0, r_reg.pre, r_reg.wdt};
      end else if (paddr[11:8] == A_MEMH) begin
        r_next.rdata = {24'h0, r_reg.mem[paddr[7:2]]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.acc <= ACC_RST;
      r_reg.pc <= PC_RST;
      r_reg.gie <= GIE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  byte_clear_a: assert property (
    issue && cmd.op == OP_CLRM && cmd.addr != PCL_ADDR |=>
      r_reg.mem[$past(cmd.addr)] == 8'h00 &&
      r_reg.fl[3:0] == $past(r_reg.fl[3:0]))
    else $error("byte clear failed");
  bit_clear_a: assert property (
    issue && cmd.op == OP_CLRB && cmd.addr != PCL_ADDR |=>
      r_reg.mem[$past(cmd.addr)] ==
      ($past(r_reg.mem[cmd.addr]) & ~(8'h01 << $past(cmd.bitsel))))
    else $error("bit clear wrong");
  wdt_clear_a: assert property (
    issue && cmd.op == OP_WDTCLR && !to_evt |=>
      r_reg.wdt == 8'h00 && !r_reg.fl.timeout_flag &&
      !r_reg.fl.power_down_flag)
    else $error("watchdog clear failed");
  pair_clear_a: assert property (
    issue && cmd.op == OP_WDT2 && r_reg.pre1 && !to_evt |=>
      r_reg.wdt == 8'h00 && !r_reg.pre1 &&
      !r_reg.fl.power_down_flag)
    else $error("paired clear failed");
  lone_pre_a: assert property (
    issue && cmd.op == OP_WDT1 && !r_reg.pre2 && !to_evt |=>
      r_reg.pre1 && $stable(r_reg.fl.power_down_flag) &&
      $stable(r_reg.fl.timeout_flag))
    else $error("lone preclear changed flags");
  invert_mem_a: assert property (
    issue && cmd.op == OP_INV && cmd.addr != PCL_ADDR |=>
      r_reg.mem[$past(cmd.addr)] == ~$past(r_reg.mem[cmd.addr]) &&
      r_reg.fl.z == (r_reg.mem[$past(cmd.addr)] == 8'h00))
    else $error("invert in place wrong");
  incr_acc_a: assert property (
    issue && cmd.op == OP_INCW && cmd.addr != PCL_ADDR |=>
      r_reg.acc == $past(r_reg.mem[cmd.addr]) + 8'h01)
    else $error("increment to accumulator wrong");
  halt_entry_a: assert property (
    issue && cmd.op == OP_HALT |=>
      halted && r_reg.fl.power_down_flag &&
      r_reg.pc == $past(r_reg.pc) + 10'h001 && r_reg.wdt == 8'h00)
    else $error("halt entry wrong");
  ret_time_a: assert property (
    issue && cmd.op == OP_RET |=> busy [*7] ##1 !busy)
    else $error("return not two cycles");
  pcl_extra_a: assert property (
    issue && cmd.op == OP_MOVWM && cmd.addr == PCL_ADDR |=>
      busy [*7] ##1 !busy)
    else $error("low pc write not extended");
  iret_gie_a: assert property (
    issue && cmd.op == OP_IRET |=> gie)
    else $error("interrupt return left gie low");

  halt_seen_c: cover property (issue && cmd.op == OP_HALT);
  jump_seen_c: cover property (issue && cmd.op == OP_JUMP);
  adj_carry_c: cover property (
    issue && cmd.op == OP_DECADJ && !r_reg.fl.c ##1 r_reg.fl.c);

endmodule
`default_nettype wire

//--- tb/mie_exec_tb.sv
// Self-checking bench for the instruction execute block
`timescale 1ns/1ps
`default_nettype none
module mie_exec_tb;
  import mie_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic        pready, pslverr, busy, halted, gie;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  int          miscompares, check_count, nb;
  int          cyc = 0;

  mie_exec u_mie_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .halted(halted), .gie(gie));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Request held from setup until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a slave that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] ma(input logic [5:0] a);
    return {A_MEMH, a, 2'b00};
  endfunction

  // Issue one instruction, then count the cycles busy stands
  task automatic ex(input logic [4:0] op, input logic [2:0] b, input logic [5:0] a,
                    input logic [9:0] g);
    apb(1'b1, A_CMD, {6'h0, g, 2'h0, a, b, op});
    #1;
    nb = 0;
    while (busy === 1'b1 && nb < 40) begin
      @(posedge pclk);
      #1;
      nb++;
    end
  endtask

  task automatic cm(input logic [5:0] a, input logic [7:0] e);
    apb(1'b0, ma(a), 32'h0);
    chk("mem", rv, {24'h0, e});
  endtask

  task automatic ca(input logic [7:0] e);
    apb(1'b0, A_ACC, 32'h0);
    chk("acc", rv, {24'h0, e});
  endtask

  // Records in the top two bits, then to, pdf, ov, z, ac, c
  task automatic cs(input logic [7:0] e);
    apb(1'b0, A_STAT, 32'h0);
    chk("stat", {24'h0, rv[12:11], rv[5:0]}, {24'h0, e});
  endtask

  task automatic cp(input logic [9:0] e);
    apb(1'b0, A_PC, 32'h0);
    chk("pc", {22'h0, rv[9:0]}, {22'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_clear;
    apb(1'b1, ma(6'h05), 32'ha5);
    apb(1'b1, A_STAT, 32'h0f);
    ex(OP_CLRM, 3'h0, 6'h05, 10'h0);
    cm(6'h05, 8'h00);
    cs(8'h0f);
    apb(1'b1, ma(6'h06), 32'hff);
    ex(OP_CLRB, 3'h3, 6'h06, 10'h0);
    cm(6'h06, 8'hf7);
    cs(8'h0f);
  endtask

  task automatic t_inv;
    apb(1'b1, ma(6'h08), 32'hff);
    apb(1'b1, A_STAT, 32'h0);
    ex(OP_INV, 3'h0, 6'h08, 10'h0);
    cm(6'h08, 8'h00);
    cs(8'h04);
    apb(1'b1, ma(6'h09), 32'h0f);
    ex(OP_INVW, 3'h0, 6'h09, 10'h0);
    ca(8'hf0);
    cm(6'h09, 8'h0f);
    cs(8'h00);
  endtask

  task automatic t_incdec;
    apb(1'b1, ma(6'h0a), 32'hff);
    ex(OP_INCM, 3'h0, 6'h0a, 10'h0);
    cm(6'h0a, 8'h00);
    cs(8'h04);
    ex(OP_INCW, 3'h0, 6'h0a, 10'h0);
    ca(8'h01);
    cm(6'h0a, 8'h00);
    cs(8'h00);
    apb(1'b1, ma(6'h0b), 32'h01);
    ex(OP_DECM, 3'h0, 6'h0b, 10'h0);
    cm(6'h0b, 8'h00);
    cs(8'h04);
    ex(OP_DECW, 3'h0, 6'h0b, 10'h0);
    ca(8'hff);
    cm(6'h0b, 8'h00);
    cs(8'h00);
  endtask

  task automatic t_move_or;
    apb(1'b1, A_STAT, 32'h0b);
    ex(OP_MOVI, 3'h0, 6'h0, 10'h03c);
    ca(8'h3c);
    ex(OP_MOVWM, 3'h0, 6'h0c, 10'h0);
    cm(6'h0c, 8'h3c);
    apb(1'b1, ma(6'h0d), 32'h81);
    ex(OP_MOVMW, 3'h0, 6'h0d, 10'h0);
    ca(8'h81);
    cs(8'h0b);
    ex(OP_ORW, 3'h0, 6'h0c, 10'h0);
    ca(8'hbd);
    ex(OP_ORI, 3'h0, 6'h0, 10'h042);
    ca(8'hff);
    cs(8'h0b);
    ex(OP_MOVI, 3'h0, 6'h0, 10'h0);
    apb(1'b1, ma(6'h0e), 32'h0);
    ex(OP_ORM, 3'h0, 6'h0e, 10'h0);
    cm(6'h0e, 8'h00);
    cs(8'h0f);
  endtask

  // Accumulator, flags in, expected memory and flags out
  task automatic adj(input logic [7:0] a, input logic [7:0] f, input logic [7:0] m,
                     input logic [7:0] fo);
    apb(1'b1, A_ACC, {24'h0, a});
    apb(1'b1, A_STAT, {24'h0, f});
    ex(OP_DECADJ, 3'h0, 6'h0f, 10'h0);
    cm(6'h0f, m);
    cs(fo);
    ca(a);
  endtask

  task automatic t_misc;
    adj(8'h9b, 8'h00, 8'h01, 8'h01);
    adj(8'h45, 8'h02, 8'h4b, 8'h02);
    adj(8'h12, 8'h01, 8'h72, 8'h01);
    adj(8'h99, 8'h00, 8'h99, 8'h00);
    apb(1'b1, A_STAT, 32'h05);
    apb(1'b1, ma(6'h10), 32'h81);
    ex(OP_ROL, 3'h0, 6'h10, 10'h0);
    cm(6'h10, 8'h03);
    cs(8'h05);
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
  endtask

  task automatic t_branch;
    apb(1'b1, A_PC, 32'h010);
    ex(OP_NOP, 3'h0, 6'h0, 10'h0);
    cp(10'h011);
    chk("cycles", nb, {28'h0, ONE_CYC});
    cs(8'h05);
    ex(OP_JUMP, 3'h0, 6'h0, 10'h2a5);
    cp(10'h2a5);
    chk("cycles", nb, {28'h0, TWO_CYC});
    apb(1'b1, A_STK, 32'h123);
    ex(OP_RET, 3'h0, 6'h0, 10'h0);
    cp(10'h123);
    chk("cycles", nb, {28'h0, TWO_CYC});
    apb(1'b1, A_STK, 32'h045);
    ex(OP_RETK, 3'h0, 6'h0, 10'h05a);
    cp(10'h045);
    ca(8'h5a);
    apb(1'b1, A_STK, 32'h077);
    chk("gie", {31'h0, gie}, 32'h0);
    ex(OP_IRET, 3'h0, 6'h0, 10'h0);
    cp(10'h077);
    chk("gie", {31'h0, gie}, 32'h1);
    cs(8'h05);
    ex(OP_MOVI, 3'h0, 6'h0, 10'h05d);
    ex(OP_MOVWM, 3'h0, PCL_ADDR, 10'h0);
    chk("cycles", nb, {28'h0, TWO_CYC});
    cp(10'h05d);
  endtask

  task automatic t_watchdog;
    apb(1'b1, A_STAT, 32'h0);
    apb(1'b1, A_PC, 32'h030);
    apb(1'b1, A_ACC, 32'h11);
    repeat (600) @(posedge pclk);
    ex(OP_HALT, 3'h0, 6'h0, 10'h0);
    chk("halted", {31'h0, halted}, 32'h1);
    apb(1'b0, A_WDT, 32'h0);
    chk("wdt", {16'h0, rv[15:0]}, 32'h0);
    cs(8'h10);
    cp(10'h031);
    ex(OP_MOVI, 3'h0, 6'h0, 10'h077);
    apb(1'b1, A_WAKE, 32'h0);
    // Let the wake edge settle before looking
    #1;
    chk("halted", {31'h0, halted}, 32'h0);
    ca(8'h11);
    repeat (600) @(posedge pclk);
    ex(OP_WDT1, 3'h0, 6'h0, 10'h0);
    cs(8'h50);
    apb(1'b0, A_WDT, 32'h0);
    chk("wdt kept", {31'h0, rv[7:0] == 8'h0}, 32'h0);
    ex(OP_WDT1, 3'h0, 6'h0, 10'h0);
    ex(OP_WDT2, 3'h0, 6'h0, 10'h0);
    cs(8'h00);
    apb(1'b0, A_WDT, 32'h0);
    chk("wdt", {24'h0, rv[7:0]}, 32'h0);
    ex(OP_HALT, 3'h0, 6'h0, 10'h0);
    apb(1'b1, A_WAKE, 32'h0);
    repeat (600) @(posedge pclk);
    ex(OP_WDTCLR, 3'h0, 6'h0, 10'h0);
    cs(8'h00);
    apb(1'b0, A_WDT, 32'h0);
    chk("wdt", {24'h0, rv[7:0]}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hang would otherwise never report
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_clear();
    t_inv();
    t_incdec();
    t_move_or();
    t_misc();
    t_branch();
    t_watchdog();
    give_verdict();
  end
endmodule
`default_nettype wire
